// [logic/cma_pkg.sv]
package cma_pkg;
  localparam int PROG_W  = 21;
  localparam int DADDR_W = 12;
  localparam logic [20:0] PROG_RST  = 21'h0;
  localparam logic [20:0] PROG_STEP = 21'h2;
  localparam logic [3:0]  PREFIX  = 4'hf;
  localparam logic [7:0]  WIN_SPLIT   = 8'h60;
  localparam logic [3:0]  WIN_LO_BANK = 4'h0;
  localparam logic [3:0]  WIN_HI_BANK = 4'hf;
  localparam logic [4:0]  BANKS_SMALL = 5'h04;
  localparam logic [4:0]  BANKS_BIG   = 5'h08;
  localparam logic [11:0] SPECIAL_START = 12'hf60;
  localparam logic [11:0] OFF_BANK  = 12'h000;
  localparam logic [11:0] OFF_CFG   = 12'h004;
  localparam logic [11:0] OFF_PROG  = 12'h008;
  localparam logic [11:0] OFF_BASE  = 12'h00c;
  localparam int CFG_EXT_BIT = 0;
  localparam int CFG_BIG_BIT = 1;
  localparam logic [3:0]  BANK_RST = 4'h0;
  localparam logic [11:0] BASE_RST = 12'h000;
  localparam logic [1:0]  CFG_RST  = 2'h0;

  typedef enum logic [2:0]
  {
    K_PLAIN, K_FILE, K_LOAD_BANK, K_JUMP, K_BRANCH, K_MOVE, K_SKIP
  } cma_kind_t;

  typedef enum logic [2:0]
  {
    ST_RUN    = 3'b001,
    ST_SECOND = 3'b010,
    ST_FLUSH  = 3'b100
  } cma_state_t;

  typedef struct packed
  {
    cma_kind_t   kind;
    logic        access_sel;
    logic [7:0]  operand;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
    logic [19:0] lit;
  } cma_op_t;

  typedef struct packed
  {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } cma_apb_req_t;

  typedef struct packed
  {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } cma_apb_rsp_t;
endpackage

// [logic/cma_addr.sv]
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
module cma_addr
  import cma_pkg::*;
(
  input  wire logic   mclk,
  input  wire logic   reset,
  input  cma_apb_req_t apb_req,
  output cma_apb_rsp_t apb_rsp,
  input  cma_op_t     exec_op,
  input  wire logic [15:0] exec_word,
  input  wire logic [7:0]  ram_rdata,
  output logic [20:0] prog_addr,
  output logic [11:0] ram_addr,
  output logic        ram_re,
  output logic        ram_we,
  output logic [7:0]  ram_wdata,
  output logic [7:0]  operand_data,
  output logic [11:0] literal_data,
  output logic        literal_valid,
  output logic        status_update
);

  function automatic logic implemented(logic [11:0] a, logic big);
    logic [4:0] nbanks;
    nbanks = big ? BANKS_BIG : BANKS_SMALL;
    implemented = (a >= SPECIAL_START) || ({1'b0, a[11:8]} < nbanks);
  endfunction

  function automatic logic [11:0] resolve(logic a_sel, logic [7:0] off,
    logic [3:0] bnk, logic ext, logic [11:0] base);
    if (a_sel)
      resolve = {bnk, off};
    else if (off >= WIN_SPLIT)
      resolve = {WIN_HI_BANK, off};
    else if (ext)
      resolve = base + {4'h0, off};
    else
      resolve = {WIN_LO_BANK, off};
  endfunction

  cma_state_t  state;
  cma_state_t  next_state;
  cma_kind_t   first_kind;
  logic [19:0] first_lit;
  logic [3:0]  bank;
  logic        cfg_ext;
  logic        cfg_big;
  logic [11:0] ext_base;
  logic        rd_impl;
  logic [20:0] next_pc;
  logic [11:0] next_ram_addr;
  logic        next_re;
  logic        next_we;
  logic [7:0]  next_wdata;
  logic        next_lit_valid;
  logic        next_status;
  logic        bank_load;
  logic        prefix;
  logic        do_second;
  logic        do_exec;
  logic [7:0]  rdata_gated;
  logic [11:0] file_addr;
  logic        apb_setup;
  logic        apb_done;
  logic        apb_mapped;
  logic [31:0] next_prdata;

  assign prefix      = exec_word[15:12] == PREFIX;
  assign do_second   = (state == ST_SECOND) && prefix;
  assign do_exec     = (state == ST_RUN) ||
                       ((state == ST_SECOND) && !prefix);
  // zero for unimplemented locations; data must stand with ram_addr
  assign rdata_gated = rd_impl ? ram_rdata : 8'h00;
  assign file_addr   = resolve(exec_op.access_sel, exec_op.operand, bank,
                               cfg_ext, ext_base);

  always_comb
  begin
    next_state     = ST_RUN;
    next_pc        = prog_addr + PROG_STEP;
    next_ram_addr  = ram_addr;
    next_re        = 1'b0;
    next_we        = 1'b0;
    next_wdata     = ram_wdata;
    next_lit_valid = 1'b0;
    next_status    = 1'b0;
    bank_load      = 1'b0;
    if (do_second)
    begin
      next_lit_valid = 1'b1;
      if (first_kind == K_JUMP)
      begin
        next_pc    = {exec_word[11:0], first_lit[7:0], 1'b0};
        next_state = ST_FLUSH;
      end
      else
      begin
        next_ram_addr = exec_word[11:0];
        next_we       = implemented(exec_word[11:0], cfg_big);
        next_wdata    = rdata_gated;
      end
    end
    else if (do_exec && !prefix)
    begin
      case (exec_op.kind)
        K_FILE:
        begin
          next_ram_addr = file_addr;
          next_re       = exec_op.rd;
          next_we       = exec_op.wr && implemented(file_addr, cfg_big);
          next_wdata    = exec_op.wdata;
          next_status   = 1'b1;
        end
        K_LOAD_BANK:
          bank_load = 1'b1;
        K_JUMP:
          next_state = ST_SECOND;
        K_MOVE:
        begin
          next_state    = ST_SECOND;
          next_ram_addr = exec_op.lit[11:0];
          next_re       = 1'b1;
        end
        K_BRANCH:
        begin
          next_pc    = prog_addr +
                       {{9{exec_op.lit[10]}}, exec_op.lit[10:0], 1'b0};
          next_state = ST_FLUSH;
        end
        K_SKIP:
          next_state = ST_FLUSH;
        default:
          next_state = ST_RUN;
      endcase
    end
    // a lone 1111 word falls through here and does nothing
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      state <= ST_RUN;
    else
      state <= next_state;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      prog_addr <= PROG_RST;
    else
      prog_addr <= {next_pc[20:1], 1'b0};
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      first_kind <= K_PLAIN;
      first_lit  <= 20'h00000;
    end
    else if (do_exec)
    begin
      first_kind <= exec_op.kind;
      first_lit  <= exec_op.lit;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ram_addr      <= 12'h000;
      ram_re        <= 1'b0;
      ram_we        <= 1'b0;
      ram_wdata     <= 8'h00;
      rd_impl       <= 1'b0;
      operand_data  <= 8'h00;
      literal_data  <= 12'h000;
      literal_valid <= 1'b0;
      status_update <= 1'b0;
    end
    else
    begin
      ram_addr      <= next_ram_addr;
      ram_re        <= next_re;
      ram_we        <= next_we;
      ram_wdata     <= next_wdata;
      rd_impl       <= implemented(next_ram_addr, cfg_big);
      operand_data  <= rdata_gated;
      literal_valid <= next_lit_valid;
      if (do_second)
        literal_data <= exec_word[11:0];
      status_update <= next_status;
    end
  end

  // register slave: one wait state, pready from a flop
  assign apb_setup  = apb_req.psel && apb_req.penable && !apb_rsp.pready;
  assign apb_done   = apb_req.psel && apb_req.penable && apb_rsp.pready;
  assign apb_mapped = (apb_req.paddr == OFF_BANK) ||
                      (apb_req.paddr == OFF_CFG) ||
                      (apb_req.paddr == OFF_PROG) ||
                      (apb_req.paddr == OFF_BASE);

  always_comb
  begin
    next_prdata = 32'h00000000;
    case (apb_req.paddr)
      OFF_BANK: next_prdata = {28'h0000000, bank};
      OFF_CFG:  next_prdata = {30'h0, cfg_big, cfg_ext};
      OFF_PROG: next_prdata = {11'h0, prog_addr};
      OFF_BASE: next_prdata = {20'h00000, ext_base};
      default:  next_prdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      apb_rsp <= '0;
    else
    begin
      apb_rsp.pready  <= apb_setup;
      apb_rsp.pslverr <= apb_setup && !apb_mapped;
      apb_rsp.prdata  <= apb_setup ? next_prdata : 32'h00000000;
    end
  end

  // instruction load wins over a bus write landing in the same cycle
  always_ff @(posedge mclk)
  begin
    if (reset)
      bank <= BANK_RST;
    else if (bank_load)
      bank <= exec_op.lit[3:0];
    else if (apb_done && apb_req.pwrite && apb_req.paddr == OFF_BANK)
      bank <= apb_req.pwdata[3:0];
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      {cfg_big, cfg_ext} <= CFG_RST;
      ext_base           <= BASE_RST;
    end
    else if (apb_done && apb_req.pwrite)
    begin
      if (apb_req.paddr == OFF_CFG)
      begin
        cfg_ext <= apb_req.pwdata[CFG_EXT_BIT];
        cfg_big <= apb_req.pwdata[CFG_BIG_BIT];
      end
      if (apb_req.paddr == OFF_BASE)
        ext_base <= apb_req.pwdata[11:0];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_pc_even;
    prog_addr[0] == 1'b0;
  endproperty
  a_pc_even: assert property (p_pc_even)
    else $error("program counter odd");

  property p_flush_step;
    state == ST_FLUSH |=> prog_addr == $past(prog_addr) + PROG_STEP
      && !ram_we && !ram_re && !status_update && state == ST_RUN;
  endproperty
  a_flush_step: assert property (p_flush_step)
    else $error("flushed word had an effect");

  property p_jump;
    do_second && first_kind == K_JUMP |=>
      prog_addr == {$past(exec_word[11:0]), $past(first_lit[7:0]), 1'b0}
      ##1 state == ST_RUN;
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump target wrong");

  property p_branch;
    do_exec && !prefix && exec_op.kind == K_BRANCH |=>
      state == ST_FLUSH && prog_addr == $past(prog_addr) +
      {{9{$past(exec_op.lit[10])}}, $past(exec_op.lit[10:0]), 1'b0};
  endproperty
  a_branch: assert property (p_branch)
    else $error("branch target wrong");

  property p_lit;
    do_second |=> literal_valid && literal_data == $past(exec_word[11:0]);
  endproperty
  a_lit: assert property (p_lit)
    else $error("second word literal lost");

  property p_lone_nop;
    state == ST_RUN && prefix |=> !ram_we && !ram_re && !status_update
      && !literal_valid && prog_addr == $past(prog_addr) + PROG_STEP;
  endproperty
  a_lone_nop: assert property (p_lone_nop)
    else $error("lone second word acted");

  property p_we_impl;
    ram_we |-> implemented(ram_addr, cfg_big);
  endproperty
  a_we_impl: assert property (p_we_impl)
    else $error("write to unimplemented bank");

  property p_rd_zero;
    !rd_impl |=> operand_data == 8'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("unimplemented read not zero");

  property p_window_hi;
    do_exec && !prefix && exec_op.kind == K_FILE && !exec_op.access_sel
      && exec_op.operand >= WIN_SPLIT |=>
      ram_addr == {WIN_HI_BANK, $past(exec_op.operand)} && status_update;
  endproperty
  a_window_hi: assert property (p_window_hi)
    else $error("window upper mapping wrong");

  property p_banked;
    do_exec && !prefix && exec_op.kind == K_FILE && exec_op.access_sel
      |=> ram_addr == {$past(bank), $past(exec_op.operand)};
  endproperty
  a_banked: assert property (p_banked)
    else $error("banked address wrong");

  property p_bank_read;
    apb_rsp.pready && apb_req.paddr == OFF_BANK |-> apb_rsp.prdata[31:4] == 0;
  endproperty
  a_bank_read: assert property (p_bank_read)
    else $error("bank register upper bits set");

  property p_move_dst;
    do_second && first_kind == K_MOVE |=>
      ram_addr == $past(exec_word[11:0]) && !status_update;
  endproperty
  a_move_dst: assert property (p_move_dst)
    else $error("file move destination wrong");

  property p_window_lo;
    do_exec && !prefix && exec_op.kind == K_FILE && !exec_op.access_sel
      && exec_op.operand < WIN_SPLIT |=> ram_addr == ($past(cfg_ext) ?
      $past(ext_base) + {4'h0, $past(exec_op.operand)} :
      {WIN_LO_BANK, $past(exec_op.operand)});
  endproperty
  a_window_lo: assert property (p_window_lo)
    else $error("window lower mapping wrong");

  property p_bank_load;
    do_exec && !prefix && exec_op.kind == K_LOAD_BANK |=>
      bank == $past(exec_op.lit[3:0]);
  endproperty
  a_bank_load: assert property (p_bank_load)
    else $error("bank load from literal lost");

  c_move: cover property (do_exec && exec_op.kind == K_MOVE ##1 do_second);
  c_skip_nop: cover property (state == ST_FLUSH ##1 state == ST_RUN && prefix);
  c_unimpl: cover property (status_update && !rd_impl);
endmodule

// [test/cma_ram_model.sv]
`timescale 1ns/100ps
module cma_ram_model
(
  input  wire logic        mclk,
  input  wire logic [11:0] ram_addr,
  input  wire logic        ram_re,
  input  wire logic        ram_we,
  input  wire logic [7:0]  ram_wdata,
  output logic      [7:0]  ram_rdata
);
  logic [7:0] mem [0:4095];

  // known fill so the bench can predict every byte
  initial
  begin
    for (int i = 0; i < 4096; i++)
      mem[i] = 8'(i) ^ 8'h3c;
  end

  always @(posedge mclk)
  begin
    if (ram_we)
      mem[ram_addr] <= ram_wdata;
  end

  // core samples read data in the cycle its address stands; inverse
  // outside reads so stale bytes never pass for fresh ones
  assign ram_rdata = ram_re ? mem[ram_addr] : ~mem[ram_addr];
endmodule

// [test/tb.sv]
`timescale 1ns/100ps
module tb;
  import cma_pkg::*;
  logic         mclk = 1'b0;
  logic         reset = 1'b1;
  cma_apb_req_t apb_req = '0;
  cma_apb_rsp_t apb_rsp;
  cma_op_t      exec_op = '0;
  logic [15:0]  exec_word = 16'h0000;
  logic [7:0]   ram_rdata, ram_wdata, operand_data;
  logic [20:0]  prog_addr, p;
  logic [11:0]  ram_addr, literal_data;
  logic         ram_re, ram_we, literal_valid, status_update, err;
  logic [31:0]  rd;
  int           failures = 0;
  int           cmp_count = 0;
  int           cyc = 0;

  cma_addr DUT
  (
    .mclk          (mclk),
    .reset         (reset),
    .apb_req       (apb_req),
    .apb_rsp       (apb_rsp),
    .exec_op       (exec_op),
    .exec_word     (exec_word),
    .ram_rdata     (ram_rdata),
    .prog_addr     (prog_addr),
    .ram_addr      (ram_addr),
    .ram_re        (ram_re),
    .ram_we        (ram_we),
    .ram_wdata     (ram_wdata),
    .operand_data  (operand_data),
    .literal_data  (literal_data),
    .literal_valid (literal_valid),
    .status_update (status_update)
  );

  cma_ram_model ram
  (
    .mclk      (mclk),
    .ram_addr  (ram_addr),
    .ram_re    (ram_re),
    .ram_we    (ram_we),
    .ram_wdata (ram_wdata),
    .ram_rdata (ram_rdata)
  );

  always #5 mclk = ~mclk;

  task automatic report_and_stop();
    if (failures == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      failures++;
      report_and_stop();
    end
  end

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge mclk);
    apb_req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    // no wait count assumed: loops until pready; only the bench timeout bounds it
    do
    begin
      @(posedge mclk);
    end
    while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask

  // one word per edge; returns once the previous word's results settled
  task automatic put(cma_kind_t k, logic a, logic [7:0] o, logic [1:0] rw,
                     logic [19:0] l, logic [15:0] wd);
    @(posedge mclk);
    exec_op <= '{kind:k, access_sel:a, operand:o, wdata:8'hc3,
                 rd:rw[1], wr:rw[0], lit:l};
    exec_word <= wd;
    #1;
  endtask

  task automatic idle(int n);
    repeat (n)
      put(K_PLAIN, 1'b0, 8'h00, 2'b00, 20'h0, 16'h0000);
  endtask

  task automatic t_regs();
    apb(1'b0, OFF_BANK, 32'h0);
    chk("bank reset", rd, 32'h0);
    apb(1'b1, OFF_BANK, 32'hffffffff);
    apb(1'b0, OFF_BANK, 32'h0);
    chk("bank upper", rd, 32'h0000000f);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", err, 1'b1);
  endtask

  task automatic t_data();
    apb(1'b1, OFF_BANK, 32'h2);
    put(K_FILE, 1'b1, 8'h34, 2'b10, 20'h0, 16'h0);
    put(K_FILE, 1'b0, 8'h5f, 2'b10, 20'h0, 16'h0);
    chk("banked", ram_addr, 12'h234);
    chk("read", ram_re, 1'b1);
    put(K_FILE, 1'b0, 8'h60, 2'b10, 20'h0, 16'h0);
    chk("win lo", ram_addr, 12'h05f);
    chk("rd data", operand_data, 8'h34 ^ 8'h3c);
    idle(1);
    chk("win hi", ram_addr, 12'hf60);
    apb(1'b1, OFF_BANK, 32'h5);
    put(K_FILE, 1'b1, 8'h10, 2'b01, 20'h0, 16'h0);
    put(K_FILE, 1'b1, 8'h10, 2'b10, 20'h0, 16'h0);
    chk("unimpl we", ram_we, 1'b0);
    chk("unimpl st", status_update, 1'b1);
    idle(2);
    chk("unimpl rd", operand_data, 8'h00);
    apb(1'b1, OFF_CFG, 32'h2);
    apb(1'b1, OFF_BANK, 32'h7);
    put(K_FILE, 1'b1, 8'h10, 2'b01, 20'h0, 16'h0);
    idle(1);
    chk("big we", ram_we, 1'b1);
    chk("big addr", ram_addr, 12'h710);
    put(K_LOAD_BANK, 1'b0, 8'h00, 2'b00, 20'h3, 16'h0);
    put(K_FILE, 1'b1, 8'h01, 2'b10, 20'h0, 16'h0);
    idle(1);
    chk("load bank", ram_addr, 12'h301);
    apb(1'b0, OFF_BANK, 32'h0);
    chk("load bank reg", rd, 32'h3);
  endtask

  task automatic t_ext();
    apb(1'b1, OFF_CFG, 32'h1);
    apb(1'b1, OFF_BASE, 32'h100);
    put(K_FILE, 1'b0, 8'h10, 2'b10, 20'h0, 16'h0);
    put(K_FILE, 1'b0, 8'h80, 2'b10, 20'h0, 16'h0);
    chk("ext lo", ram_addr, 12'h110);
    idle(1);
    chk("ext hi", ram_addr, 12'hf80);
    apb(1'b1, OFF_CFG, 32'h0);
  endtask

  task automatic t_flow();
    put(K_JUMP, 1'b0, 8'h00, 2'b00, 20'h45, 16'h0);
    put(K_PLAIN, 1'b0, 8'h00, 2'b00, 20'h0, 16'hf123);
    put(K_FILE, 1'b0, 8'h10, 2'b01, 20'h0, 16'h0);
    chk("jump pc", prog_addr, 21'h02468a);
    chk("lit valid", literal_valid, 1'b1);
    chk("lit data", literal_data, 12'h123);
    idle(1);
    chk("flushed", ram_we, 1'b0);
    put(K_PLAIN, 1'b0, 8'h00, 2'b00, 20'h0, 16'hf456);
    idle(1);
    chk("lone lit", literal_valid, 1'b0);
    chk("lone st", status_update, 1'b0);
    chk("lone we", ram_we | ram_re, 1'b0);
    put(K_BRANCH, 1'b0, 8'h00, 2'b00, 20'h7fd, 16'h0);
    p = prog_addr;
    idle(1);
    chk("branch", prog_addr, p - 21'd6);
    idle(1);
    chk("pc step", prog_addr, p - 21'd4);
  endtask

  task automatic t_move();
    put(K_MOVE, 1'b1, 8'h00, 2'b00, 20'h123, 16'h0);
    put(K_PLAIN, 1'b0, 8'h00, 2'b00, 20'h0, 16'hf056);
    chk("mv src", ram_addr, 12'h123);
    chk("mv src re", ram_re, 1'b1);
    idle(1);
    chk("mv we", ram_we, 1'b1);
    chk("mv dst", ram_addr, 12'h056);
    chk("mv data", ram_wdata, 8'h23 ^ 8'h3c);
  endtask

  initial
  begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    idle(1);
    chk("pc first", prog_addr, 21'h2);
    idle(1);
    chk("pc even", prog_addr, 21'h4);
    t_regs();
    t_data();
    t_ext();
    t_flow();
    t_move();
    report_and_stop();
  end
endmodule
